// >>> strap_led_pkg.sv
// Shared constants and types for the strap and indicator pin block
package strap_led_pkg;

  // Register byte offsets
  localparam logic [11:0] ADDR_WAN_MISC = 12'h000;
  localparam logic [11:0] ADDR_STRAP    = 12'h004;

  // Field positions
  localparam int LED_A_LSB    = 0;
  localparam int LED_B_LSB    = 4;
  localparam int STRAP_POL    = 0;
  localparam int STRAP_WIDTH  = 1;
  localparam int STRAP_RSVD   = 3;
  localparam int STRAP_RUN    = 4;

  // Reset values
  localparam logic [2:0] LED_SEL_RESET = 3'h0;
  localparam logic [1:0] WIDTH_RESET   = 2'h0;

  // Indicator select codes
  localparam logic [2:0] LED_SPEED    = 3'h0;
  localparam logic [2:0] LED_LINK     = 3'h1;
  localparam logic [2:0] LED_DUPLEX   = 3'h2;
  localparam logic [2:0] LED_COLL     = 3'h3;
  localparam logic [2:0] LED_ACT      = 3'h4;
  localparam logic [2:0] LED_FD_COLL  = 3'h5;
  localparam logic [2:0] LED_LINK_ACT = 3'h6;

  // Boot bank width codes
  localparam logic [1:0] WIDTH_RSVD = 2'h0;
  localparam logic [1:0] WIDTH_BYTE = 2'h1;
  localparam logic [1:0] WIDTH_HALF = 2'h2;
  localparam logic [1:0] WIDTH_WORD = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {PH_CAPTURE, PH_RUN} phase_e;

  // Port status from the WAN port
  typedef struct packed {
    logic speed;
    logic link;
    logic duplex;
    logic collision;
    logic activity;
    logic fd_collision;
  } wan_status_s;

  typedef struct packed {
    phase_e      phase;
    logic        wdog_pol;
    logic [1:0]  boot_width;
    logic [2:0]  sel_a;
    logic [2:0]  sel_b;
    logic        oe_n;
    logic        oe_en;
    logic [3:0]  byte_write_n;
    logic        led_a;
    logic        led_b;
    logic        led_en;
    logic        wdog_rst;
    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic        w_strb0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_s;

endpackage

// >>> strap_and_led_pin_functions.sv
// Dual-role strap, static memory strobe and WAN indicator pin logic
// Functional notes
// - Output enable pin driven low enables devices
// - Output enable pin sampled as watchdog polarity
// - Four active-low byte write strobes, not SDRAM
// - Indicator A follows select bits 2..0
// - Indicator B follows select bits 6..4
// - Select codes: speed, link, duplex, collision, more
// - Indicator pins sampled as boot width code
// - Boot bank 0 uses captured width
`timescale 1ns/1ps
`default_nettype none

module strap_and_led_pin_functions
  import strap_led_pkg::*;
(
  input  wire logic                      core_clk_in,
  input  wire logic                      sys_rst_in,
  // AXI4-Lite slave
  input  wire logic [11:0]               s_axi_awaddr_in,
  input  wire logic                      s_axi_awvalid_in,
  output var  logic                      s_axi_awready_out,
  input  wire logic [31:0]               s_axi_wdata_in,
  input  wire logic [3:0]                s_axi_wstrb_in,
  input  wire logic                      s_axi_wvalid_in,
  output var  logic                      s_axi_wready_out,
  output var  logic [1:0]                s_axi_bresp_out,
  output var  logic                      s_axi_bvalid_out,
  input  wire logic                      s_axi_bready_in,
  input  wire logic [11:0]               s_axi_araddr_in,
  input  wire logic                      s_axi_arvalid_in,
  output var  logic                      s_axi_arready_out,
  output var  logic [31:0]               s_axi_rdata_out,
  output var  logic [1:0]                s_axi_rresp_out,
  output var  logic                      s_axi_rvalid_out,
  input  wire logic                      s_axi_rready_in,
  input  wire logic                      s_axi_bready_unused_in,
  // Memory controller side
  input  wire logic                      mem_read_req_in,
  input  wire logic [3:0]                mem_byte_write_in,
  input  wire strap_led_pkg::wan_status_s wan_status_in,
  input  wire logic                      wdog_reset_req_in,
  // Shared output enable / polarity strap pin
  input  wire logic                      static_mem_output_enable_n_in,
  output var  logic                      static_mem_output_enable_n_out,
  output var  logic                      static_mem_output_enable_n_oe_out,
  output var  logic [3:0]                static_mem_byte_write_n_out,
  // Indicator / boot width strap pins
  input  wire logic                      wan_indicator_a_in,
  output var  logic                      wan_indicator_a_out,
  output var  logic                      wan_indicator_a_oe_out,
  input  wire logic                      wan_indicator_b_in,
  output var  logic                      wan_indicator_b_out,
  output var  logic                      wan_indicator_b_oe_out,
  // Captured configuration and watchdog reset output
  output var  logic                      watchdog_reset_polarity_strap_out,
  output var  logic [1:0]                boot_bank_width_strap_out,
  output var  logic                      watchdog_reset_out
);
  import strap_led_pkg::*;

  state_s st;
  state_s next_st;

  // Indicator level for a select code; unused code 111 keeps it dark
  function automatic logic led_pick(input logic [2:0] sel,
                                    input wan_status_s s);
    logic v;
    v = 1'b0;
    case (sel)
      LED_SPEED:    v = s.speed;
      LED_LINK:     v = s.link;
      LED_DUPLEX:   v = s.duplex;
      LED_COLL:     v = s.collision;
      LED_ACT:      v = s.activity;
      LED_FD_COLL:  v = s.fd_collision;
      LED_LINK_ACT: v = s.link & ~s.activity;
      default:      v = 1'b0;
    endcase
    return v;
  endfunction

  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] rd_word;
  logic [1:0]  rd_resp;
  logic        run;

  assign run = (st.phase == PH_RUN);

  always_comb begin
    next_st = st;
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    rd_word = 32'h0000_0000;
    rd_resp = RESP_OKAY;

    // Pins stay inputs for the one cycle after release so the straps
    // are sampled before anything drives them
    case (st.phase)
      PH_CAPTURE: begin
        next_st.wdog_pol   = static_mem_output_enable_n_in;
        next_st.boot_width = {wan_indicator_b_in,
                              wan_indicator_a_in};
        next_st.phase      = PH_RUN;
      end
      PH_RUN: begin
        next_st.phase = PH_RUN;
      end
      default: next_st.phase = PH_CAPTURE;
    endcase

    next_st.oe_en  = (next_st.phase == PH_RUN);
    next_st.led_en = (next_st.phase == PH_RUN);
    next_st.oe_n   = ~(run & mem_read_req_in);
    next_st.byte_write_n = run ? ~mem_byte_write_in
                               : 4'hf;
    next_st.led_a = run & led_pick(st.sel_a, wan_status_in);
    next_st.led_b = run & led_pick(st.sel_b, wan_status_in);
    // Polarity strap 0 means the reset pulse is driven low
    next_st.wdog_rst = run ? (wdog_reset_req_in ~^ st.wdog_pol)
                           : 1'b0;

    // Write channel: address and data may arrive in either order
    if (s_axi_awvalid_in && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && st.wready) begin
      next_st.w_held  = 1'b1;
      next_st.w_data  = s_axi_wdata_in;
      next_st.w_strb0 = s_axi_wstrb_in[0];
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      wr_fire         = 1'b1;
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = RESP_OKAY;
      if (st.aw_addr == ADDR_WAN_MISC) begin
        if (st.w_strb0) begin
          next_st.sel_a = st.w_data[LED_A_LSB +: 3];
          next_st.sel_b = st.w_data[LED_B_LSB +: 3];
        end
      end else if (st.aw_addr == ADDR_STRAP) begin
        next_st.bresp = RESP_OKAY;
      end else begin
        next_st.bresp = RESP_SLVERR;
      end
    end
    if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = ~next_st.aw_held & ~next_st.bvalid & ~wr_fire;
    next_st.wready  = ~next_st.w_held & ~next_st.bvalid & ~wr_fire;

    // Read channel: one read at a time, answer the cycle after
    if (s_axi_arvalid_in && st.arready) begin
      rd_fire = 1'b1;
      if (s_axi_araddr_in == ADDR_WAN_MISC) begin
        rd_word[LED_A_LSB +: 3] = st.sel_a;
        rd_word[LED_B_LSB +: 3] = st.sel_b;
      end else if (s_axi_araddr_in == ADDR_STRAP) begin
        rd_word[STRAP_POL]          = st.wdog_pol;
        rd_word[STRAP_WIDTH +: 2]   = st.boot_width;
        rd_word[STRAP_RSVD]         = (st.boot_width == WIDTH_RSVD);
        rd_word[STRAP_RUN]          = run;
      end else begin
        rd_resp = RESP_SLVERR;
      end
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_word;
      next_st.rresp  = rd_resp;
    end
    if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = ~next_st.rvalid & ~rd_fire;
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st              <= '0;
      st.phase        <= PH_CAPTURE;
      st.boot_width   <= WIDTH_RESET;
      st.sel_a        <= LED_SEL_RESET;
      st.sel_b        <= LED_SEL_RESET;
      st.oe_n         <= 1'b1;
      st.byte_write_n <= 4'hf;
    end else begin
      st <= next_st;
    end
  end

  assign static_mem_output_enable_n_out    = st.oe_n;
  assign static_mem_output_enable_n_oe_out = st.oe_en;
  assign static_mem_byte_write_n_out       = st.byte_write_n;
  assign wan_indicator_a_out               = st.led_a;
  assign wan_indicator_a_oe_out            = st.led_en;
  assign wan_indicator_b_out               = st.led_b;
  assign wan_indicator_b_oe_out            = st.led_en;
  assign watchdog_reset_polarity_strap_out = st.wdog_pol;
  assign boot_bank_width_strap_out         = st.boot_width;
  assign watchdog_reset_out                = st.wdog_rst;
  assign s_axi_awready_out                 = st.awready;
  assign s_axi_wready_out                  = st.wready;
  assign s_axi_bvalid_out                  = st.bvalid;
  assign s_axi_bresp_out                   = st.bresp;
  assign s_axi_arready_out                 = st.arready;
  assign s_axi_rvalid_out                  = st.rvalid;
  assign s_axi_rdata_out                   = st.rdata;
  assign s_axi_rresp_out                   = st.rresp;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_oe_drive;
    run && mem_read_req_in |=>
      !static_mem_output_enable_n_out && static_mem_output_enable_n_oe_out;
  endproperty
  a_oe_drive: assert property (p_oe_drive)
    else $error("output enable not driven low on read");

  property p_pol_capture;
    !run |=> watchdog_reset_polarity_strap_out
             == $past(static_mem_output_enable_n_in);
  endproperty
  a_pol_capture: assert property (p_pol_capture)
    else $error("polarity strap not captured");

  property p_byte_write;
    run |=> static_mem_byte_write_n_out == ~$past(mem_byte_write_in);
  endproperty
  a_byte_write: assert property (p_byte_write)
    else $error("byte write strobes wrong");

  property p_led_a_link;
    run && st.sel_a == LED_LINK |=>
      wan_indicator_a_out == $past(wan_status_in.link);
  endproperty
  a_led_a_link: assert property (p_led_a_link)
    else $error("indicator A does not follow link");

  property p_led_b_speed;
    run && st.sel_b == LED_SPEED |=>
      wan_indicator_b_out == $past(wan_status_in.speed);
  endproperty
  a_led_b_speed: assert property (p_led_b_speed)
    else $error("indicator B does not follow speed");

  property p_led_link_act;
    run && st.sel_a == LED_LINK_ACT |=> wan_indicator_a_out ==
      $past(wan_status_in.link && !wan_status_in.activity);
  endproperty
  a_led_link_act: assert property (p_led_link_act)
    else $error("link/activity code wrong");

  property p_width_capture;
    !run |-> !wan_indicator_a_oe_out ##1
      boot_bank_width_strap_out == {$past(wan_indicator_b_in),
                                    $past(wan_indicator_a_in)};
  endproperty
  a_width_capture: assert property (p_width_capture)
    else $error("width strap not captured with pins released");

  property p_width_hold;
    run |=> $stable(boot_bank_width_strap_out)[*2];
  endproperty
  a_width_hold: assert property (p_width_hold)
    else $error("boot width changed after capture");

  // Run and the drive enables flip on the same edge, so the capture edge
  // is the only one that may see the pins released
  property p_enable_after;
    !run |-> !static_mem_output_enable_n_oe_out && !wan_indicator_b_oe_out
      ##1 static_mem_output_enable_n_oe_out && wan_indicator_b_oe_out;
  endproperty
  a_enable_after: assert property (p_enable_after)
    else $error("pins enabled at wrong time");

  property p_pol_hold;
    run |=> $stable(watchdog_reset_polarity_strap_out);
  endproperty
  a_pol_hold: assert property (p_pol_hold)
    else $error("polarity strap changed after capture");

  property p_strobe_quiet;
    !run |=> static_mem_byte_write_n_out == 4'hf &&
             static_mem_output_enable_n_out;
  endproperty
  a_strobe_quiet: assert property (p_strobe_quiet)
    else $error("memory strobes active during capture");

  property p_wdog_quiet;
    !run |=> !watchdog_reset_out;
  endproperty
  a_wdog_quiet: assert property (p_wdog_quiet)
    else $error("watchdog reset driven during capture");

endmodule
`default_nettype wire

// >>> strap_board_model.sv
// Board model: strap resistors and level resolution of the shared pins
`timescale 1ns/1ps
`default_nettype none

module strap_board_model (
  input  wire logic       pol_strap_in,
  input  wire logic [1:0] width_strap_in,
  input  wire logic       oe_n_drive_in,
  input  wire logic       oe_n_en_in,
  input  wire logic       led_a_drive_in,
  input  wire logic       led_a_en_in,
  input  wire logic       led_b_drive_in,
  input  wire logic       led_b_en_in,
  output logic            oe_n_pin_out,
  output logic            led_a_pin_out,
  output logic            led_b_pin_out
);
  // Strap resistors hold each released pin; an enabled driver wins
  assign oe_n_pin_out  = oe_n_en_in ? oe_n_drive_in : pol_strap_in;
  assign led_a_pin_out = led_a_en_in ? led_a_drive_in
                                     : width_strap_in[0];
  assign led_b_pin_out = led_b_en_in ? led_b_drive_in
                                     : width_strap_in[1];
endmodule

`default_nettype wire

// >>> strap_and_led_pin_functions_tb.sv
// Testbench for the strap and indicator pin block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module strap_and_led_pin_functions_tb_top;
  import strap_led_pkg::*;
  logic        core_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, rd_req, wd_req;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, data;
  logic [3:0]  wstrb, bw_req, bw_n;
  logic [1:0]  bresp, rresp, resp, width_strap, width_cap;
  logic [2:0]  ca, cb;
  wan_status_s wan_status;
  logic        pol_strap, pol_cap, wdog_out, oe_n_pin, led_a_pin, led_b_pin;
  logic        oe_n_drv, oe_n_en, a_drv, a_en, b_drv, b_en;
  int          mismatches, checked;
  logic [2:0]  cfg [4] = '{3'b110, 3'b000, 3'b101, 3'b011};
  logic [5:0]  stat [3] = '{6'h15, 6'h2a, 6'h12};

  strap_and_led_pin_functions strap_and_led_pin_functions_inst (
    .core_clk_in(core_clk), .sys_rst_in(sys_rst),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .s_axi_bready_unused_in(1'b0),
    .mem_read_req_in(rd_req), .mem_byte_write_in(bw_req),
    .wan_status_in(wan_status), .wdog_reset_req_in(wd_req),
    .static_mem_output_enable_n_in(oe_n_pin),
    .static_mem_output_enable_n_out(oe_n_drv),
    .static_mem_output_enable_n_oe_out(oe_n_en),
    .static_mem_byte_write_n_out(bw_n),
    .wan_indicator_a_in(led_a_pin), .wan_indicator_a_out(a_drv),
    .wan_indicator_a_oe_out(a_en), .wan_indicator_b_in(led_b_pin),
    .wan_indicator_b_out(b_drv), .wan_indicator_b_oe_out(b_en),
    .watchdog_reset_polarity_strap_out(pol_cap),
    .boot_bank_width_strap_out(width_cap), .watchdog_reset_out(wdog_out));

  strap_board_model strap_board_model_inst (
    .pol_strap_in(pol_strap), .width_strap_in(width_strap),
    .oe_n_drive_in(oe_n_drv), .oe_n_en_in(oe_n_en),
    .led_a_drive_in(a_drv), .led_a_en_in(a_en),
    .led_b_drive_in(b_drv), .led_b_en_in(b_en),
    .oe_n_pin_out(oe_n_pin), .led_a_pin_out(led_a_pin),
    .led_b_pin_out(led_b_pin));

  function automatic logic led_exp(input logic [2:0] c, input logic [5:0] s);
    case (c)
      3'h6: return s[4] & ~s[1];
      3'h7: return 1'b0;
      default: return s[3'h5 - c];
    endcase
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Checks at an edge read values settled before that edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // No cycle count is assumed; only the watchdog ends a hung wait
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    resp = rresp;
    data = rdata;
    rready <= 1'b0;
  endtask

  // Requests stay asserted through reset to prove the pins stay quiet
  task automatic do_reset(input logic p, input logic [1:0] w);
    pol_strap <= p;
    width_strap <= w;
    bw_req <= 4'hf;
    rd_req <= 1'b1;
    sys_rst <= 1'b1;
    tick(12);
    `CHK("pins_in_reset", 3'h0, {oe_n_en, a_en, b_en})
    `CHK("strobes_in_reset", 5'h1f, {bw_n, oe_n_drv})
    sys_rst <= 1'b0;
    // At the capture edge the pins must still be released
    tick(1);
    `CHK("pins_capture", 3'h0, {oe_n_en, a_en, b_en})
    tick(1);
    pol_strap <= ~p;
    width_strap <= ~w;
    bw_req <= 4'h0;
    rd_req <= 1'b0;
    tick(2);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  initial begin
    {sys_rst, awvalid, wvalid, bready, arvalid, rready} <= 6'h20;
    {rd_req, wd_req, pol_strap, width_strap, bw_req} <= '0;
    {awaddr, araddr, wdata, wstrb} <= '0;
    wan_status <= '0;
    mismatches = 0;
    checked = 0;
    for (int i = 0; i < 4; i++) begin
      do_reset(cfg[i][2], cfg[i][1:0]);
      `CHK("polarity", cfg[i][2], pol_cap)
      `CHK("width", cfg[i][1:0], width_cap)
      `CHK("pins_run", 3'h7, {oe_n_en, a_en, b_en})
      axi_rd(ADDR_STRAP);
      `CHK("status", {28'h1, cfg[i][1:0] == WIDTH_RSVD, cfg[i][1:0], cfg[i][2]}, data)
      for (int r = 0; r < 2; r++) begin
        wd_req <= r[0];
        tick(3);
        `CHK("wdog", r[0] ~^ cfg[i][2], wdog_out)
      end
      $display("test straps %0d done", i);
    end
    rd_req <= 1'b1;
    tick(3);
    `CHK("oe_low", 1'b0, oe_n_pin)
    rd_req <= 1'b0;
    tick(3);
    `CHK("oe_high", 1'b1, oe_n_pin)
    for (int l = 0; l < 4; l++) begin
      bw_req <= 4'h1 << l;
      tick(3);
      `CHK("byte_write", ~(4'h1 << l), bw_n)
    end
    $display("test strobes done");
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 8; c++) begin
        ca = c[2:0];
        cb = ~ca;
        wan_status <= wan_status_s'(stat[s]);
        axi_wr(ADDR_WAN_MISC, {8'hab, 17'h0, cb, 1'b0, ca}, 4'hf);
        tick(2);
        `CHK("led_a", led_exp(ca, stat[s]), led_a_pin)
        `CHK("led_b", led_exp(cb, stat[s]), led_b_pin)
        axi_rd(ADDR_WAN_MISC);
        `CHK("sel", {25'h0, cb, 1'b0, ca}, data)
      end
    end
    $display("test indicators done");
    axi_wr(ADDR_WAN_MISC, 32'h33, 4'h0);
    axi_rd(ADDR_WAN_MISC);
    `CHK("strobe_off", 32'h7, data)
    axi_wr(ADDR_STRAP, 32'h0, 4'hf);
    `CHK("ro_resp", RESP_OKAY, resp)
    axi_rd(ADDR_STRAP);
    `CHK("ro_keep", 32'h16, data)
    axi_wr(12'h100, 32'h1, 4'hf);
    `CHK("bad_wr", RESP_SLVERR, resp)
    axi_rd(12'h100);
    `CHK("bad_rd", {RESP_SLVERR, 32'h0}, {resp, data})
    $display("test registers done");
    print_verdict();
  end
endmodule

`default_nettype wire
